// ### inc/scl_regs.svh
// Register map, field positions and constants for the serial clock/coding/loop block
`ifndef SCL_REGS_SVH
`define SCL_REGS_SVH
`define SCL_ADDR_CTRL 3'h0
`define SCL_ADDR_TC 3'h1
`define SCL_ADDR_CLKSRC 3'h2
`define SCL_ADDR_STATUS 3'h3
`define SCL_CTRL_RESET 16'h0000
`define SCL_TC_RESET 16'h0000
`define SCL_CLKSRC_RESET 6'h00
`define SCL_EOP_PATTERN 8'hFE
`define SCL_ST_BRG_ZERO 0
`define SCL_ST_EOP_SEEN 1
`define SCL_ST_EOP_END 2
`define SCL_ST_CTS_CHG 3
`define SCL_ST_DCD_CHG 4
`define SCL_ST_BRG_OUT 8
`define SCL_ST_CTS 9
`define SCL_ST_DCD 10
`define SCL_ST_LOOP_SEND 11
`define SCL_ST_EOP_ACTIVE 12
`define SCL_CLOCK_RECOVERY_LOOP_LAST 5'h1F
`define SCL_CLOCK_RECOVERY_LOOP_MID 5'h10
`define SCL_CLOCK_RECOVERY_LOOP_WIN_LO 5'h08
`define SCL_CLOCK_RECOVERY_LOOP_WIN_HI 5'h17
`define SCL_CLOCK_RECOVERY_LOOP_H1_A 5'h04
`define SCL_CLOCK_RECOVERY_LOOP_BIT_A 5'h0C
`define SCL_CLOCK_RECOVERY_LOOP_H1_B 5'h14
`define SCL_CLOCK_RECOVERY_LOOP_BIT_B 5'h1C
`endif

// ### inc/scl_pkg.sv
// Types shared by the serial clock/coding/loop block
package scl_pkg;
  typedef enum logic [1:0] {SCL_NRZ, SCL_NRZI, SCL_BIMARK, SCL_BISPACE} scl_code_t;
  typedef enum logic [1:0] {SCL_SRC_PIN, SCL_SRC_BRG, SCL_SRC_CLOCK_RECOVERY_LOOP, SCL_SRC_BIDIR} scl_src_t;
  typedef struct packed {
    logic [1:0] clock_mode;
    logic osc_en;
    logic brg_src_pin;
    logic clock_recovery_loop_src_brg;
    logic clock_recovery_loop_biphase;
    logic clock_recovery_loop_en;
    scl_code_t tx_code;
    scl_code_t rx_code;
    logic local_loop;
    logic auto_echo;
    logic msg_pending;
    logic loop_mode;
    logic brg_en;
  } scl_ctrl_t;
  typedef struct packed {
    logic [1:0] pin_sel;
    scl_src_t tx_src;
    scl_src_t rx_src;
  } scl_clksrc_t;
  typedef struct packed {
    logic bit_val;
    logic valid;
  } scl_bit_t;
endpackage

// ### rtl/scl_core.sv
// Serial line clocking, coding and loop relay for one channel
//
// Local design decisions: the Avalon-MM register port and the register addresses.
`timescale 1ns/100ps
`default_nettype none
`include "scl_regs.svh"
module scl_core (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  input wire logic [4:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  input wire logic i_rxd,
  output logic o_txd,
  input wire logic i_clock_input_pin,
  input wire logic i_bidir_clock_pin,
  output logic o_bidir_clock_pin,
  output logic o_bidir_clock_pin_oe,
  input wire logic i_cts_n,
  input wire logic i_carrier_detect_in_n,
  output logic o_osc_en,
  input wire logic i_tx_bit,
  input wire logic i_tx_last,
  output logic o_tx_take,
  output var scl_pkg::scl_bit_t o_rx,
  output logic o_tx_enable,
  output logic o_rx_enable,
  output logic o_ext_event
);
  typedef enum {LP_RELAY, LP_SEND, LP_CLOSE} scl_loop_t;
  localparam logic [7:0] EOP_BITS = `SCL_EOP_PATTERN;

  function automatic logic [5:0] mode_last(input logic [1:0] mode);
    case (mode)
      2'h0: mode_last = 6'h00;
      2'h1: mode_last = 6'h0F;
      2'h2: mode_last = 6'h1F;
      default: mode_last = 6'h3F;
    endcase
  endfunction

  function automatic logic pick_tick(input scl_pkg::scl_src_t src, input logic pin,
                                     input logic brg, input logic clock_recovery_loop, input logic bidir);
    case (src)
      scl_pkg::SCL_SRC_PIN: pick_tick = pin;
      scl_pkg::SCL_SRC_BRG: pick_tick = brg;
      scl_pkg::SCL_SRC_CLOCK_RECOVERY_LOOP: pick_tick = clock_recovery_loop;
      default: pick_tick = bidir;
    endcase
  endfunction

  scl_pkg::scl_ctrl_t ctrl;
  scl_pkg::scl_clksrc_t clksrc;
  logic [15:0] tc;
  logic [4:0] stat;
  logic rd_done;
  logic [2:0] word;
  logic wr_en;
  logic [15:0] next_ctrl;
  logic [4:0] evt;

  // Pin synchronisers; stage one is read only by stage two
  logic [1:0] rxd_s, cin_s, bid_s, cts_s, dcd_s;
  logic cin_d, bid_d, cts_d, dcd_d;
  logic cin_rise, bid_rise;

  logic brg_out, brg_load, brg_en_d, brg_zero, brg_rise;
  logic [15:0] brg_cnt;

  logic [4:0] dp_cnt;
  logic dp_line_d, dp_edge, dp_ref;
  logic [1:0] dp_adj;
  logic dp_bit, dp_h1;

  logic [5:0] rx_div, tx_div;
  logic rx_src_tick, tx_src_tick, rx_tick, tx_tick;
  logic rx_line, rx_h1_lvl, rx_prev_lvl, rx_bit, rx_bit_ok;

  logic tx_level, tx_phase, tx_cur, tx_bit_tick;
  logic [7:0] rx_hist;
  logic relay_hold, eop_now, eop_active, loop_out;
  logic [2:0] close_cnt;
  scl_loop_t loop_st;

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      rxd_s <= 2'h0;
      cin_s <= 2'h0;
      bid_s <= 2'h0;
      cts_s <= 2'h3;
      dcd_s <= 2'h3;
    end
    else if (i_ce)
    begin
      rxd_s <= {rxd_s[0], i_rxd};
      cin_s <= {cin_s[0], i_clock_input_pin};
      bid_s <= {bid_s[0], i_bidir_clock_pin};
      cts_s <= {cts_s[0], i_cts_n};
      dcd_s <= {dcd_s[0], i_carrier_detect_in_n};
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      cin_d <= 1'b0;
      bid_d <= 1'b0;
      cts_d <= 1'b1;
      dcd_d <= 1'b1;
    end
    else if (i_ce)
    begin
      cin_d <= cin_s[1];
      bid_d <= bid_s[1];
      cts_d <= cts_s[1];
      dcd_d <= dcd_s[1];
    end
  end

  assign cin_rise = cin_s[1] & ~cin_d;
  assign bid_rise = bid_s[1] & ~bid_d;

  // Avalon slave: writes finish at once, reads take one wait cycle
  assign word = i_avs_address[4:2];
  assign wr_en = i_ce & i_avs_write;
  assign o_avs_waitrequest = i_avs_read & ~rd_done;
  assign next_ctrl = {i_avs_byteenable[1] ? i_avs_writedata[15:8] : ctrl[15:8],
                      i_avs_byteenable[0] ? i_avs_writedata[7:0] : ctrl[7:0]};

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      ctrl <= `SCL_CTRL_RESET;
      clksrc <= `SCL_CLKSRC_RESET;
      tc <= `SCL_TC_RESET;
    end
    else if (wr_en)
    begin
      if (word == `SCL_ADDR_CTRL)
        ctrl <= next_ctrl;
      if (word == `SCL_ADDR_CLKSRC && i_avs_byteenable[0])
        clksrc <= i_avs_writedata[5:0];
      // Byte writes let software load the two time-constant halves apart
      if (word == `SCL_ADDR_TC && i_avs_byteenable[0])
        tc[7:0] <= i_avs_writedata[7:0];
      if (word == `SCL_ADDR_TC && i_avs_byteenable[1])
        tc[15:8] <= i_avs_writedata[15:8];
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      rd_done <= 1'b0;
      o_avs_readdata <= 32'h0000_0000;
    end
    else if (i_ce)
    begin
      rd_done <= i_avs_read & ~rd_done;
      if (i_avs_read && !rd_done)
      begin
        case (word)
          `SCL_ADDR_CTRL: o_avs_readdata <= {16'h0000, ctrl};
          `SCL_ADDR_TC: o_avs_readdata <= {16'h0000, tc};
          `SCL_ADDR_CLKSRC: o_avs_readdata <= {26'h0, clksrc};
          `SCL_ADDR_STATUS: o_avs_readdata <= {19'h0_0000, eop_active,
            loop_st == LP_SEND, ~dcd_s[1], ~cts_s[1], brg_out, 3'h0, stat};
          default: o_avs_readdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Sticky external status bits, write one to clear; a new event beats the clear
  assign evt[`SCL_ST_BRG_ZERO] = brg_zero;
  assign evt[`SCL_ST_EOP_SEEN] = rx_bit_ok & eop_now;
  assign evt[`SCL_ST_EOP_END] = rx_bit_ok & eop_active & ~rx_bit;
  assign evt[`SCL_ST_CTS_CHG] = cts_s[1] ^ cts_d;
  assign evt[`SCL_ST_DCD_CHG] = dcd_s[1] ^ dcd_d;

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      stat <= 5'h00;
    else if (i_ce)
    begin
      if (wr_en && word == `SCL_ADDR_STATUS && i_avs_byteenable[0])
        stat <= (stat & ~i_avs_writedata[4:0]) | evt;
      else
        stat <= stat | evt;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      o_ext_event <= 1'b0;
    else if (i_ce)
      o_ext_event <= |evt;
  end

  // Rate generator; one load tick per half period makes it 2*(tc+2)
  logic brg_in;
  assign brg_in = ctrl.brg_src_pin ? cin_rise : 1'b1;
  assign brg_zero = i_ce & ctrl.brg_en & brg_en_d & brg_in & ~brg_load & (brg_cnt == 16'h0000);
  assign brg_rise = brg_zero & ~brg_out;

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      brg_out <= 1'b1;
      brg_load <= 1'b1;
      brg_en_d <= 1'b0;
      brg_cnt <= 16'h0000;
    end
    else if (i_ce)
    begin
      brg_en_d <= ctrl.brg_en;
      if (ctrl.brg_en && !brg_en_d)
      begin
        brg_out <= 1'b1;
        brg_load <= 1'b1;
      end
      else if (ctrl.brg_en && brg_in)
      begin
        if (brg_load)
        begin
          brg_cnt <= tc;
          brg_load <= 1'b0;
        end
        else if (brg_cnt == 16'h0000)
        begin
          brg_out <= ~brg_out;
          brg_load <= 1'b1;
        end
        else
          brg_cnt <= brg_cnt - 16'h0001;
      end
    end
  end

  // Recovery loop: reference from input pin or generator
  assign dp_ref = ctrl.clock_recovery_loop_src_brg ? brg_rise : cin_rise;
  assign dp_edge = dp_ref & (rx_line ^ dp_line_d);

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      dp_cnt <= 5'h00;
      dp_line_d <= 1'b0;
      dp_adj <= 2'h0;
    end
    else if (i_ce && ctrl.clock_recovery_loop_en && dp_ref)
    begin
      dp_line_d <= rx_line;
      if (dp_edge && !ctrl.clock_recovery_loop_biphase && dp_cnt != 5'h00)
        dp_adj <= dp_cnt < `SCL_CLOCK_RECOVERY_LOOP_MID ? 2'h1 : 2'h2;
      else if (dp_edge && ctrl.clock_recovery_loop_biphase && dp_cnt >= `SCL_CLOCK_RECOVERY_LOOP_WIN_LO &&
               dp_cnt <= `SCL_CLOCK_RECOVERY_LOOP_WIN_HI && dp_cnt != `SCL_CLOCK_RECOVERY_LOOP_MID)
        dp_adj <= dp_cnt < `SCL_CLOCK_RECOVERY_LOOP_MID ? 2'h2 : 2'h1;
      if (dp_cnt == `SCL_CLOCK_RECOVERY_LOOP_LAST)
      begin
        if (dp_adj == 2'h1)
          dp_adj <= 2'h0;
        else
        begin
          dp_cnt <= dp_adj == 2'h2 ? 5'h01 : 5'h00;
          dp_adj <= 2'h0;
        end
      end
      else
        dp_cnt <= dp_cnt + 5'h01;
    end
  end

  // Bit and first-half sample points taken from the loop count
  always_comb
  begin
    dp_bit = 1'b0;
    dp_h1 = 1'b0;
    if (ctrl.clock_recovery_loop_en && dp_ref)
    begin
      if (ctrl.clock_recovery_loop_biphase)
      begin
        dp_bit = dp_cnt == `SCL_CLOCK_RECOVERY_LOOP_BIT_A || dp_cnt == `SCL_CLOCK_RECOVERY_LOOP_BIT_B;
        dp_h1 = dp_cnt == `SCL_CLOCK_RECOVERY_LOOP_H1_A || dp_cnt == `SCL_CLOCK_RECOVERY_LOOP_H1_B;
      end
      else
        dp_bit = dp_cnt == `SCL_CLOCK_RECOVERY_LOOP_MID;
    end
  end

  // Clock selection and mode divisors
  assign rx_src_tick = pick_tick(clksrc.rx_src, cin_rise, brg_rise, dp_bit, bid_rise);
  assign tx_src_tick = pick_tick(clksrc.tx_src, cin_rise, brg_rise, dp_bit, bid_rise);
  assign rx_tick = rx_src_tick & (clksrc.rx_src == scl_pkg::SCL_SRC_CLOCK_RECOVERY_LOOP ||
                   rx_div == mode_last(ctrl.clock_mode));
  assign tx_tick = tx_src_tick & (clksrc.tx_src == scl_pkg::SCL_SRC_CLOCK_RECOVERY_LOOP ||
                   tx_div == mode_last(ctrl.clock_mode));

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      rx_div <= 6'h00;
      tx_div <= 6'h00;
    end
    else if (i_ce)
    begin
      if (rx_src_tick)
        rx_div <= rx_div >= mode_last(ctrl.clock_mode) ? 6'h00 : rx_div + 6'h01;
      if (tx_src_tick)
        tx_div <= tx_div >= mode_last(ctrl.clock_mode) ? 6'h00 : tx_div + 6'h01;
    end
  end

  // Receive decoder
  assign rx_line = ctrl.local_loop ? tx_level : rxd_s[1];
  assign rx_bit_ok = i_ce & rx_tick & (ctrl.local_loop | ~dcd_s[1]);

  always_comb
  begin
    case (ctrl.rx_code)
      scl_pkg::SCL_NRZ: rx_bit = ctrl.clock_recovery_loop_biphase ? rx_h1_lvl : rx_line;
      scl_pkg::SCL_NRZI: rx_bit = rx_line == rx_prev_lvl;
      scl_pkg::SCL_BIMARK: rx_bit = rx_line != rx_h1_lvl;
      default: rx_bit = rx_line == rx_h1_lvl;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      rx_h1_lvl <= 1'b0;
      rx_prev_lvl <= 1'b0;
      o_rx <= '0;
    end
    else if (i_ce)
    begin
      if (dp_h1)
        rx_h1_lvl <= rx_line;
      if (rx_tick)
        rx_prev_lvl <= rx_line;
      o_rx.valid <= rx_bit_ok;
      if (rx_bit_ok)
        o_rx.bit_val <= rx_bit;
    end
  end

  // Loop relay: one-bit store, end-of-poll match, insertion after match only
  assign eop_now = {rx_hist[6:0], rx_bit} == `SCL_EOP_PATTERN;

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      rx_hist <= 8'h00;
      relay_hold <= 1'b1;
      eop_active <= 1'b0;
      loop_st <= LP_RELAY;
      close_cnt <= 3'h0;
    end
    else if (rx_bit_ok && ctrl.loop_mode)
    begin
      rx_hist <= {rx_hist[6:0], rx_bit};
      relay_hold <= rx_bit;
      if (eop_now)
        eop_active <= 1'b1;
      else if (!rx_bit)
        eop_active <= 1'b0;
      case (loop_st)
        LP_RELAY:
        begin
          if (eop_now && ctrl.msg_pending)
            loop_st <= LP_SEND;
        end
        LP_SEND:
        begin
          if (i_tx_last)
          begin
            loop_st <= LP_CLOSE;
            close_cnt <= 3'h7;
          end
        end
        LP_CLOSE:
        begin
          close_cnt <= close_cnt - 3'h1;
          if (close_cnt == 3'h0)
            loop_st <= LP_RELAY;
        end
        default: loop_st <= LP_RELAY;
      endcase
    end
    else if (i_ce && !ctrl.loop_mode)
      loop_st <= LP_RELAY;
  end

  // Output straight from the one-bit store, so the last one can still be cleared
  always_comb
  begin
    case (loop_st)
      LP_SEND: loop_out = i_tx_bit;
      LP_CLOSE: loop_out = EOP_BITS[close_cnt];
      default: loop_out = relay_hold & ~(eop_now & ctrl.msg_pending);
    endcase
  end

  // Transmit encoder; biphase codes spend two transmit clocks per bit outside loop mode, one in loop mode
  assign tx_bit_tick = i_ce & (ctrl.loop_mode ? rx_bit_ok : tx_tick & ~tx_phase);
  assign o_tx_take = tx_bit_tick & (~ctrl.loop_mode | loop_st == LP_SEND);

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      tx_level <= 1'b1;
      tx_phase <= 1'b0;
      tx_cur <= 1'b1;
    end
    else if (i_ce && (tx_bit_tick || (tx_tick && tx_phase)))
    begin
      if (tx_phase)
      begin
        tx_phase <= 1'b0;
        if ((ctrl.tx_code == scl_pkg::SCL_BIMARK) == tx_cur)
          tx_level <= ~tx_level;
      end
      else
      begin
        tx_cur <= ctrl.loop_mode ? loop_out : i_tx_bit;
        case (ctrl.tx_code)
          scl_pkg::SCL_NRZ: tx_level <= ctrl.loop_mode ? loop_out : i_tx_bit;
          scl_pkg::SCL_NRZI: tx_level <= tx_level ^ ~(ctrl.loop_mode ? loop_out : i_tx_bit);
          default:
          begin
            tx_level <= ~tx_level;
            tx_phase <= ~ctrl.loop_mode;
          end
        endcase
      end
    end
  end

  // Echo modes bypass the coder entirely
  assign o_txd = (ctrl.auto_echo | ctrl.local_loop) ? rxd_s[1] : tx_level;
  assign o_tx_enable = ctrl.auto_echo | ctrl.local_loop | ~cts_s[1];
  assign o_rx_enable = ctrl.local_loop | ~dcd_s[1];
  assign o_osc_en = ctrl.osc_en;

  // Clock pin only driven when no clock path uses it as input
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_bidir_clock_pin <= 1'b0;
      o_bidir_clock_pin_oe <= 1'b0;
    end
    else if (i_ce)
    begin
      o_bidir_clock_pin_oe <= clksrc.pin_sel != 2'h0 &&
        clksrc.rx_src != scl_pkg::SCL_SRC_BIDIR && clksrc.tx_src != scl_pkg::SCL_SRC_BIDIR;
      o_bidir_clock_pin <= clksrc.pin_sel == 2'h1 ? brg_out : dp_cnt[4];
    end
  end
endmodule
`default_nettype wire

// ### tb/scl_core_properties.sv
// Port-level properties of the serial clock/coding/loop block
`timescale 1ns/100ps
`default_nettype none
module scl_properties (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  input wire logic [4:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] o_avs_readdata,
  input wire logic o_avs_waitrequest,
  input wire logic o_osc_en,
  input wire logic o_tx_take,
  input wire scl_pkg::scl_bit_t o_rx,
  input wire logic o_ext_event
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);
  a_write_no_wait: assert property (i_avs_write |-> !o_avs_waitrequest)
    else $error("write stalled");
  a_idle_no_wait: assert property (!i_avs_read |-> !o_avs_waitrequest)
    else $error("stall without request");
  a_read_first_wait: assert property ($rose(i_avs_read) |-> o_avs_waitrequest)
    else $error("read answered too early");
  a_read_answer_bound: assert property (i_avs_read && i_ce |-> ##[0:1] !o_avs_waitrequest)
    else $error("read answer late");
  a_unmapped_reads_zero: assert property (
    i_avs_read && !o_avs_waitrequest && i_avs_address[4] |-> o_avs_readdata == 32'h0)
    else $error("unmapped word not zero");
  a_readdata_holds: assert property (!$past(i_avs_read) |-> $stable(o_avs_readdata))
    else $error("read data moved");
  a_osc_by_write: assert property ($changed(o_osc_en) |-> $past(i_avs_write))
    else $error("oscillator enable moved alone");
  a_rx_single_pulse: assert property (o_rx.valid |=> !o_rx.valid)
    else $error("receive strobe too long");
  a_take_single_pulse: assert property (o_tx_take |=> !o_tx_take)
    else $error("take strobe too long");
  c_take: cover property (o_tx_take);
  c_event: cover property (o_ext_event);
  c_read_done: cover property (i_avs_read && !o_avs_waitrequest);
endmodule
bind scl_core scl_properties scl_properties_inst (
  .i_clk(i_clk),
  .i_rst_n(i_rst_n),
  .i_ce(i_ce),
  .i_avs_address(i_avs_address),
  .i_avs_read(i_avs_read),
  .i_avs_write(i_avs_write),
  .o_avs_readdata(o_avs_readdata),
  .o_avs_waitrequest(o_avs_waitrequest),
  .o_osc_en(o_osc_en),
  .o_tx_take(o_tx_take),
  .o_rx(o_rx),
  .o_ext_event(o_ext_event)
);
`default_nettype wire

// ### tb/scl_line_model.sv
// Far-end loop controller: bit source with its own line clock
`timescale 1ns/100ps
`default_nettype none
module scl_line_model #(
  parameter int HALF = 8
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_txd,
  output logic o_rxd,
  output logic o_lclk
);
  logic q[$];
  logic cap[$];
  logic armed;
  int cnt;
  // First bit first, so an end-of-poll leads with its ones
  task automatic push_byte(input logic [7:0] b);
    for (int i = 7; i >= 0; i--)
      q.push_back(b[i]);
  endtask
  function automatic bit idle();
    return q.size() == 0 && !armed && !o_lclk && cnt == 0;
  endfunction
  // Clock stands low outside frames; line marks high when idle
  always @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_lclk <= 1'b0;
      o_rxd <= 1'b1;
      armed <= 1'b0;
      cnt <= 0;
    end
    else if (cnt != 0)
      cnt <= cnt - 1;
    else if (o_lclk)
    begin
      o_lclk <= 1'b0;
      cnt <= HALF - 1;
    end
    else if (armed)
    begin
      o_lclk <= 1'b1;
      armed <= 1'b0;
      cap.push_back(i_txd);
      cnt <= HALF - 1;
    end
    else if (q.size() != 0)
    begin
      o_rxd <= q.pop_front();
      armed <= 1'b1;
      cnt <= HALF - 1;
    end
    else
      o_rxd <= 1'b1;
  end
endmodule
`default_nettype wire

// ### tb/test_serial_channel_clock_coding_loop.sv
// Self-checking bench for the serial clock/coding/loop block
`timescale 1ns/100ps
`default_nettype none
`include "scl_regs.svh"
module test_serial_channel_clock_coding_loop;
  logic i_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic [4:0] adr = 5'h00;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wd = 32'h0;
  logic tx_bit = 1'b1;
  logic tx_last = 1'b0;
  logic echo_on = 1'b0;
  logic ce = 1'b1;
  logic [1:0] h = 2'h3;
  logic [31:0] rdata;
  logic waitreq, txd, lclk, rxd, bo, boe, take, ev;
  scl_pkg::scl_bit_t rx;
  // Pull-up holds the two-way pin when nobody drives it
  wire logic pin = boe ? bo : 1'b1;
  int error_cnt = 0;
  int checks = 0;
  int takes = 0;
  int evs = 0;
  int regs[8];
  logic rx_q[$];
  logic sent[$];
  logic msg[$];
  scl_core scl_core_inst (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_ce(ce),
    .i_avs_address(adr), .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wd),
    .i_avs_byteenable(4'h3), .o_avs_readdata(rdata), .o_avs_waitrequest(waitreq),
    .i_rxd(rxd), .o_txd(txd), .i_clock_input_pin(lclk), .i_bidir_clock_pin(pin),
    .o_bidir_clock_pin(bo), .o_bidir_clock_pin_oe(boe), .i_cts_n(1'b0),
    .i_carrier_detect_in_n(1'b0), .o_osc_en(), .i_tx_bit(tx_bit), .i_tx_last(tx_last),
    .o_tx_take(take), .o_rx(rx), .o_tx_enable(), .o_rx_enable(), .o_ext_event(ev));
  scl_line_model #(.HALF(8)) scl_line_model_inst (.i_clk(i_clk), .i_rst_n(i_rst_n),
    .i_txd(txd), .o_rxd(rxd), .o_lclk(lclk));
  always #10 i_clk = ~i_clk;
  always @(posedge i_clk)
  begin
    h <= {h[0], rxd};
    if (echo_on)
      chk(txd, h[1], "echo");
    if (rx.valid === 1'b1)
      rx_q.push_back(rx.bit_val);
    if (ev === 1'b1)
      evs++;
    if (take === 1'b1)
    begin
      takes++;
      tx_bit <= (takes < msg.size()) ? msg[takes] : 1'b1;
      tx_last <= (takes == msg.size() - 1);
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask
  task automatic end_sim;
    $display("mismatches %0d of %0d", error_cnt, checks);
    if (error_cnt == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // Holds the request until waitrequest is seen low at an edge
  task automatic bus(input logic w, input logic [2:0] a, input logic [31:0] d,
    output logic [31:0] q);
    int n;
    logic s;
    n = 0;
    @(posedge i_clk);
    adr <= {a, 2'b00};
    wr <= w;
    rd <= !w;
    wd <= d;
    do
    begin
      @(posedge i_clk);
      s = waitreq;
      q = rdata;
      n++;
    end
    while (s !== 1'b0 && n < 40);
    rd <= 1'b0;
    wr <= 1'b0;
    if (n >= 40)
    begin
      error_cnt++;
      end_sim();
    end
    if (w && a < 3)
      regs[a] = d & ((a == 2) ? 32'h3F : 32'hFFFF);
  endtask
  task automatic wreg(input logic [2:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rchk(input logic [2:0] a);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(q, regs[a], "register read");
  endtask
  task automatic send(input logic [7:0] b);
    scl_line_model_inst.push_byte(b);
    for (int i = 7; i >= 0; i--)
      sent.push_back(b[i]);
  endtask
  task automatic wait_line;
    int n;
    n = 0;
    while (!scl_line_model_inst.idle() && n < 9000)
    begin
      @(posedge i_clk);
      n++;
    end
    chk(n < 9000, 1, "line hang");
    if (n >= 9000)
      end_sim();
  endtask
  // Level seen at this negedge lasts n cycles
  task automatic half(output int n);
    logic v;
    v = bo;
    n = 0;
    while (bo === v && n < 300)
    begin
      @(negedge i_clk);
      n++;
    end
  endtask
  function automatic int zero_at(input logic z[$]);
    foreach (z[i])
      if (z[i] === 1'b0)
        return i;
    return -99;
  endfunction
  initial
  begin
    repeat (100000) @(posedge i_clk);
    error_cnt++;
    end_sim();
  end
  initial
  begin
    logic [31:0] q;
    scl_pkg::scl_ctrl_t c;
    logic e[$];
    int tc, nt, n, off;
    void'($urandom(32'h1D71C8D3));
    regs = '{default: 0};
    regs[0] = `SCL_CTRL_RESET;
    regs[1] = `SCL_TC_RESET;
    regs[2] = `SCL_CLKSRC_RESET;
    repeat (20) @(posedge i_clk);
    i_rst_n <= 1'b1;
    // Reset values, then random traffic including an unmapped word
    repeat (4)
    begin
      for (int a = 0; a < 8; a++)
        if (a != 3)
          rchk(3'(a));
      for (int a = 0; a < 3; a++)
        wreg(3'(a), $urandom());
      wreg(3'h5, $urandom());
      chk(scl_core_inst.o_osc_en, regs[0][13], "oscillator enable");
    end
    wreg(`SCL_ADDR_CTRL, 32'h0);
    // Generator echoed on the two-way pin; new constant waits for reload
    tc = $urandom_range(11, 4);
    nt = $urandom_range(11, 4);
    wreg(`SCL_ADDR_TC, tc);
    wreg(`SCL_ADDR_CLKSRC, 32'h10);
    c = '0;
    c.brg_en = 1'b1;
    wreg(`SCL_ADDR_CTRL, {16'h0, c});
    repeat (3) @(negedge i_clk);
    chk(bo, 1'b1, "start level");
    chk(boe, 1'b1, "pin drive");
    half(n);
    half(n);
    chk(n, tc + 2, "low half");
    half(n);
    chk(n, tc + 2, "high half");
    wreg(`SCL_ADDR_TC, nt);
    @(negedge i_clk);
    half(n);
    half(n);
    chk(n, nt + 2, "reloaded half");
    bus(1'b0, `SCL_ADDR_STATUS, 32'h0, q);
    chk(q[0], 1'b1, "zero count event");
    chk(evs != 0, 1, "event pulse");
    // Low enable must freeze the running generator
    ce <= 1'b0;
    @(negedge i_clk);
    n = bo;
    repeat (30)
    begin
      @(negedge i_clk);
      chk(bo, n, "frozen by enable");
    end
    @(posedge i_clk);
    ce <= 1'b1;
    wreg(`SCL_ADDR_CTRL, 32'h0);
    wreg(`SCL_ADDR_CLKSRC, 32'h0);
    // Station with nothing pending only relays and receives
    c = '0;
    c.loop_mode = 1'b1;
    wreg(`SCL_ADDR_CTRL, {16'h0, c});
    for (int k = 0; k < 2; k++)
    begin
      // Prime the relay with a byte ending in ones so stale line state cannot fake a zero
      send(8'h5F);
      wait_line();
      wreg(`SCL_ADDR_CTRL, {16'h0, c});
      rx_q.delete();
      sent.delete();
      scl_line_model_inst.cap.delete();
      msg.delete();
      for (int i = 0; i < 6; i++)
        msg.push_back(1'($urandom_range(1, 0)));
      takes = 0;
      tx_bit <= msg[0];
      tx_last <= 1'b0;
      for (int i = 0; i < 2; i++)
        send(k ? 8'h55 : 8'($urandom()));
      send(8'hFE);
      repeat (5) send(k ? 8'h55 : 8'($urandom()));
      wait_line();
      off = zero_at(scl_line_model_inst.cap) - zero_at(sent);
      chk(off == 1 || off == 2, 1, "relay delay");
      if (k == 0)
      begin
        for (int i = 0; i + off < sent.size(); i++)
          chk(scl_line_model_inst.cap[i + off], sent[i], "relay");
        chk(rx_q.size(), sent.size(), "receive count");
        foreach (rx_q[i])
          chk(rx_q[i], sent[i], "received bit");
        chk(takes, 0, "idle takes");
        c.msg_pending = 1'b1;
      end
      else
      begin
        // Last one of end-of-poll turns to zero, then message, then new poll end
        e.delete();
        for (int i = 0; i < 21; i++)
          e.push_back(i < 6 ? 1'b1 : i < 7 ? 1'b0 : i < 13 ? msg[i - 7] : (i != 20));
        foreach (e[i])
          chk(scl_line_model_inst.cap[16 + off + i], e[i], "flag and message");
        chk(takes, 6, "message bits");
        bus(1'b0, `SCL_ADDR_STATUS, 32'h0, q);
        chk(q[1], 1'b1, "end-of-poll seen");
      end
    end
    // Echo and local loopback: transmit line copies receive line
    for (int m = 3; m < 5; m++)
    begin
      wreg(`SCL_ADDR_CTRL, 32'h1 << m);
      repeat (4) @(posedge i_clk);
      echo_on <= 1'b1;
      repeat (4) send(8'($urandom()));
      wait_line();
      echo_on <= 1'b0;
    end
    end_sim();
  end
endmodule
`default_nettype wire
